// [pkg/asq_cfg.svh]
// Constants of the converter serial port sequencer.
// Assumes inclusion by bare name from pkg/ and src/ files.
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH

// ************************************************************
// Serial word layout
// ************************************************************
`define ASQ_CMD_W 8
`define ASQ_MAX_LEN 17
`define ASQ_CNT_W 5
`define ASQ_RES_W 13
`define ASQ_DEF_WORD_LEN 5'h0D
`define ASQ_LEN_SEL1 5'h11
`define ASQ_LEN_SEL2 5'h09
`define ASQ_CH_LSB 0
`define ASQ_CH_W 3
`define ASQ_LEN_LSB 3
`define ASQ_LEN_W 2
`define ASQ_MODE_LSB 5
`define ASQ_MODE_W 3

// ************************************************************
// Cycle counts in conversion clocks
// ************************************************************
`define ASQ_ACQ_CLKS 6
`define ASQ_PROGRAM_ENABLE_N_CLKS 44
`define ASQ_CAL_CLKS 256
`define ASQ_ZERO_CLKS 76
`define ASQ_PD_CLKS 8

`endif

// [pkg/asq_pkg.sv]
// Types shared by the converter serial port sequencer.
// Assumes asq_cfg.svh is on the include path.
`include "asq_cfg.svh"

package asq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQUIRE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_AUX = 2'b11
    } asq_state_t;

    typedef enum logic [2:0] {
        MODE_CONVERT = 3'b000,
        MODE_AUTOCAL = 3'b001,
        MODE_AUTOZERO = 3'b010,
        MODE_POWERDOWN = 3'b011
    } asq_mode_t;

    // Programmed length field to serial pulses per sequence
    function automatic logic [`ASQ_CNT_W-1:0] asq_len_decode(
        input logic [`ASQ_LEN_W-1:0] sel
    );
        case (sel)
            2'h1: asq_len_decode = `ASQ_LEN_SEL1;
            2'h2: asq_len_decode = `ASQ_LEN_SEL2;
            default: asq_len_decode = `ASQ_DEF_WORD_LEN;
        endcase
    endfunction

endpackage

// [src/asq_sync.sv]
// Two-stage level synchroniser into the conversion clock domain.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/1ns
`default_nettype none

module asq_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock) begin
        if (rst) begin
            stage1 <= INIT;
            q <= INIT;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule // asq_sync

`default_nettype wire

// [src/asq_link.sv]
// Serial-clock side of the port: command shifter and result output.
// Assumes the serial clock stops between frames; chip select ends frames.
`timescale 1ns/1ns
`default_nettype none
`include "asq_cfg.svh"

module asq_link (
    input wire logic sclk,
    input wire logic sysRst,
    input wire logic chipSelectN,
    input wire logic serialIn,
    input wire logic programEnableN,
    input wire logic cmdAck,
    input wire logic [`ASQ_MAX_LEN-1:0] resultWord,
    output logic [`ASQ_CMD_W-1:0] cmdWord,
    output logic cmdReq,
    output logic serialOut,
    output logic outputDoneFlag
);
    import asq_pkg::*;

    logic [`ASQ_CNT_W-1:0] bitCount;
    logic [`ASQ_CNT_W-1:0] outCount;
    logic [`ASQ_CNT_W-1:0] wordLen;
    logic [`ASQ_CNT_W-1:0] outLen;
    logic [`ASQ_CMD_W-1:0] shiftIn;
    logic [1:0] ackSync;
    logic [1:0] progSync;
    logic seqDone;
    logic inWrap;

    assign inWrap = (bitCount == wordLen - 5'h01);

    // ************************************************************
    // Crossings into the serial clock domain
    // ************************************************************
    always_ff @(posedge sclk or posedge sysRst) begin
        if (sysRst) begin
            ackSync <= 2'h0;
            progSync <= 2'h0;
        end else begin
            ackSync <= {ackSync[0], cmdAck};
            progSync <= {progSync[0], programEnableN};
        end
    end

    // ************************************************************
    // Rising edges: command capture
    // ************************************************************
    always_ff @(posedge sclk or posedge chipSelectN or posedge sysRst) begin
        if (chipSelectN || sysRst) begin
            bitCount <= 5'h00; // [R17]
        end else if (inWrap) begin
            bitCount <= 5'h00; // [R17] [R09]
        end else begin
            bitCount <= bitCount + 5'h01;
        end
    end

    always_ff @(posedge sclk or posedge sysRst) begin
        if (sysRst) begin
            shiftIn <= 8'h00;
        end else if (!chipSelectN && !progSync[1] && bitCount < 5'(`ASQ_CMD_W)) begin
            // Only the first eight bits form the command; later ones are ignored
            shiftIn <= {shiftIn[`ASQ_CMD_W-2:0], serialIn}; // [R01] [R16]
        end
    end

    // Word held until the other domain acknowledges; later words drop
    always_ff @(posedge sclk or posedge sysRst) begin
        if (sysRst) begin
            cmdWord <= 8'h00;
            cmdReq <= 1'b0;
            wordLen <= `ASQ_DEF_WORD_LEN; // [R10]
        end else if (!chipSelectN && inWrap && !progSync[1]) begin
            wordLen <= asq_len_decode(shiftIn[`ASQ_LEN_LSB+:`ASQ_LEN_W]); // [R11]
            if (cmdReq == ackSync[1]) begin
                cmdWord <= shiftIn; // [R13]
                cmdReq <= ~cmdReq;
            end
        end
    end

    // ************************************************************
    // Falling edges: result output and done flag
    // ************************************************************
    always_ff @(negedge sclk or posedge chipSelectN or posedge sysRst) begin
        if (chipSelectN || sysRst) begin
            outCount <= 5'h00; // [R05]
            seqDone <= 1'b0;
        end else if (outCount == outLen - 5'h01) begin
            outCount <= 5'h00; // [R04]
            seqDone <= 1'b1; // [R12]
        end else begin
            outCount <= outCount + 5'h01; // [R03]
            seqDone <= 1'b0;
        end
    end

    // Length switches only between sequences, never mid-word
    always_ff @(negedge sclk or posedge sysRst) begin
        if (sysRst) begin
            outLen <= `ASQ_DEF_WORD_LEN; // [R10]
        end else if (!chipSelectN && outCount == outLen - 5'h01) begin
            outLen <= wordLen; // [R11]
        end
    end

    assign serialOut = resultWord[5'(`ASQ_MAX_LEN - 1) - outCount]; // [R03]
    assign outputDoneFlag = chipSelectN | seqDone; // [R12]
endmodule // asq_link

`default_nettype wire

// [src/asq_sequencer.sv]
// Serial port sequencer of a successive-approximation converter.
// Assumes the analog core supplies conversionResult when conversion ends.
//
// Functional notes
// R01: Chip select low: serial input shifts in on each serial clock rise.
// R02: Serial output driven with chip select low, released when high.
// R03: Result bits after the first appear on successive falling edges.
// R04: Continuous select: first result bit appears at end-of-conversion rise.
// R05: Toggled select: first result bit appears at chip select fall.
// R06: Host lowers chip select only while serial clock is low.
// R07: Chip select fall during conversion aborts it and starts a new one.
// R08: Host discards output data of a transfer that aborted a conversion.
// R09: Continuous select: host gives exactly the expected pulse count.
// R10: After power-up thirteen serial pulses per sequence are expected.
// R11: Pulses per sequence equal the programmed output word length.
// R12: Done flag low while shifting out, high after the final bit.
// R13: Shifted-in word selects input channel and operating mode.
// R14: Conversion and acquisition timed by conversion clock, not serial clock.
// R15: End-of-conversion low while any cycle runs, rises when done.
// R16: Program enable high: ignore input, no new conversion.
// R17: Bit counter restarts on chip select fall, ends at word length.
`timescale 1ns/1ns
`default_nettype none
`include "asq_cfg.svh"

module asq_sequencer #(
    parameter int ACQ_CLKS = `ASQ_ACQ_CLKS,
    parameter int PROGRAM_ENABLE_N_CLKS = `ASQ_PROGRAM_ENABLE_N_CLKS,
    parameter int CAL_CLKS = `ASQ_CAL_CLKS,
    parameter int ZERO_CLKS = `ASQ_ZERO_CLKS,
    parameter int PD_CLKS = `ASQ_PD_CLKS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic serialClock,
    input wire logic chipSelectN,
    input wire logic serialIn,
    input wire logic programEnableN,
    input wire logic [`ASQ_RES_W-1:0] conversionResult,
    output logic serialOut,
    output logic serialOutEn,
    output logic outputDoneFlag,
    output logic endOfConversion,
    output logic sampleEnable,
    output logic [`ASQ_CH_W-1:0] channelSelect,
    output asq_pkg::asq_mode_t operatingMode
);
    import asq_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    // Sequencer state and cycle timing
    asq_state_t state;
    asq_state_t next_state;
    logic [15:0] cycleCount;
    logic [15:0] cycleLimit;
    logic [15:0] auxLimit;

    // Pins and handshake on the conversion clock
    logic csSync;
    logic csPrev;
    logic csFall;
    logic progSync;
    logic reqSync;
    logic cmdAck;
    logic cmdReq;
    logic cmdArrive;
    logic [`ASQ_CMD_W-1:0] cmdWord;

    // Result, decode and link outputs
    logic [`ASQ_MAX_LEN-1:0] resultHold;
    logic lastCycle;
    logic busy;
    logic doAbort;
    logic doStart;
    logic linkOut;
    logic linkDone;
    asq_mode_t cmdMode;

    // Cycle length of each timed state
    function automatic logic [15:0] limit_of(input int clks);
        limit_of = 16'(clks - 1);
    endfunction

    // ************************************************************
    // Pin and cross-domain synchronisers
    // ************************************************************
    asq_sync #(
        .WIDTH(1),
        .INIT(1'b1)
    ) uCsSync (
        .clock(clock),
        .rst(sys_rst),
        .d(chipSelectN),
        .q(csSync)
    );

    // Read-only level; acknowledges still flow, only starts are gated
    asq_sync #(
        .WIDTH(1),
        .INIT(1'b1)
    ) uProgSync (
        .clock(clock),
        .rst(sys_rst),
        .d(programEnableN),
        .q(progSync)
    );

    // Handshake request; command word is stable while it is pending
    asq_sync #(
        .WIDTH(1),
        .INIT(1'b0)
    ) uReqSync (
        .clock(clock),
        .rst(sys_rst),
        .d(cmdReq),
        .q(reqSync)
    );

    // Resets to the idle level, so no false fall follows reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            csPrev <= 1'b1;
        end else begin
            csPrev <= csSync;
        end
    end

    // Fall seen two clocks after the pin; abort re-checks busy then
    assign csFall = csPrev & ~csSync;
    assign cmdArrive = (reqSync != cmdAck);

    // ************************************************************
    // Serial clock side
    // ************************************************************
    asq_link uLink (
        .sclk(serialClock),
        .sysRst(sys_rst),
        .chipSelectN(chipSelectN),
        .serialIn(serialIn),
        .programEnableN(programEnableN),
        .cmdAck(cmdAck),
        .resultWord(resultHold),
        .cmdWord(cmdWord),
        .cmdReq(cmdReq),
        .serialOut(linkOut),
        .outputDoneFlag(linkDone)
    );

    // ************************************************************
    // Link-facing outputs
    // ************************************************************
    // Enable straight from the pin: the bus must release without a clock
    assign serialOutEn = ~chipSelectN; // [R02]
    assign serialOut = chipSelectN ? 1'b0 : linkOut; // [R02]
    assign outputDoneFlag = linkDone; // [R12]

    // ************************************************************
    // Command decode
    // ************************************************************
    assign cmdMode = asq_mode_t'(cmdWord[`ASQ_MODE_LSB+:`ASQ_MODE_W]);
    assign busy = (state != ST_IDLE);

    // Abort wins over a command arriving in the same cycle
    assign doAbort = csFall && busy; // [R07]
    assign doStart = cmdArrive && !busy && !progSync; // [R16]

    // Registered mode: the link may rewrite cmdWord while a cycle runs
    always_comb begin
        case (operatingMode)
            MODE_AUTOCAL: auxLimit = limit_of(CAL_CLKS);
            MODE_AUTOZERO: auxLimit = limit_of(ZERO_CLKS);
            MODE_POWERDOWN: auxLimit = limit_of(PD_CLKS);
            default: auxLimit = limit_of(PROGRAM_ENABLE_N_CLKS);
        endcase
    end

    always_comb begin
        case (state)
            ST_ACQUIRE: cycleLimit = limit_of(ACQ_CLKS); // [R14]
            ST_CONVERT: cycleLimit = limit_of(PROGRAM_ENABLE_N_CLKS); // [R14]
            ST_AUX: cycleLimit = auxLimit;
            default: cycleLimit = 16'h0000;
        endcase
    end

    assign lastCycle = (cycleCount == cycleLimit);

    // ************************************************************
    // Command handshake
    // ************************************************************
    // Toggle handshake: cmdAck follows reqSync once the word is taken
    // Commands are held off while busy; words that reach the link while one is pending are dropped
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmdAck <= 1'b0;
        end else if (cmdArrive && !busy) begin
            cmdAck <= reqSync;
        end
    end

    // Channel and mode hold until the next accepted command
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            channelSelect <= 3'h0;
            operatingMode <= MODE_CONVERT;
        end else if (doStart) begin
            channelSelect <= cmdWord[`ASQ_CH_LSB+:`ASQ_CH_W]; // [R13]
            operatingMode <= cmdMode; // [R13]
        end
    end

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (doStart) begin
                    if (cmdMode == MODE_CONVERT) begin
                        next_state = ST_ACQUIRE;
                    end else begin
                        next_state = ST_AUX;
                    end
                end
            end
            // Acquisition counted in conversion clocks
            ST_ACQUIRE: begin
                if (lastCycle) begin
                    next_state = ST_CONVERT;
                end
            end
            // Result captured on the closing edge
            ST_CONVERT: begin
                if (lastCycle) begin
                    next_state = ST_IDLE;
                end
            end
            ST_AUX: begin
                if (lastCycle) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (doAbort) begin
            next_state = progSync ? ST_IDLE : ST_ACQUIRE; // [R07] [R16]
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Restarts on every state change, so each interval counts from zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cycleCount <= 16'h0000;
        end else if (doAbort || next_state != state || !busy) begin
            cycleCount <= 16'h0000;
        end else begin
            cycleCount <= cycleCount + 16'h0001; // [R14]
        end
    end

    // ************************************************************
    // Result and status
    // ************************************************************
    // Left-aligned so the first bit out is always the sign bit
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            resultHold <= 17'h00000;
        end else if (state == ST_CONVERT && lastCycle && !doAbort) begin
            resultHold <= {conversionResult, 4'h0}; // [R04]
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    // From next_state so the pins line up with the state register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            endOfConversion <= 1'b1;
        end else begin
            endOfConversion <= (next_state == ST_IDLE); // [R15]
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sampleEnable <= 1'b0;
        end else begin
            sampleEnable <= (next_state == ST_ACQUIRE); // [R14]
        end
    end
endmodule // asq_sequencer

`default_nettype wire

// [tb/asq_sequencer_properties.sv]
// Port-level concurrent checks for the converter serial port sequencer.
// Assumes it is bound to asq_sequencer and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module asq_sequencer_checker #(
    parameter int ACQ_CLKS = 6,
    parameter int PROGRAM_ENABLE_N_CLKS = 44
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic chipSelectN,
    input wire logic programEnableN,
    input wire logic serialOutEn,
    input wire logic outputDoneFlag,
    input wire logic endOfConversion,
    input wire logic sampleEnable,
    input wire asq_pkg::asq_mode_t operatingMode
);
    import asq_pkg::*;

    // ****************************************
    // Cycle counters
    // ****************************************
    int acqCount;
    int convCount;
    int peCount;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    always_ff @(posedge clock) begin
        if (sys_rst || !sampleEnable) acqCount <= 0;
        else acqCount <= acqCount + 1;
    end

    always_ff @(posedge clock) begin
        if (sys_rst || sampleEnable || endOfConversion) convCount <= 0;
        else convCount <= convCount + 1;
    end

    // Saturates so a long read-only stretch cannot wrap
    always_ff @(posedge clock) begin
        if (sys_rst || !programEnableN) peCount <= 0;
        else if (peCount < 15) peCount <= peCount + 1;
    end

    a_oe_tracks_select: assert property (serialOutEn == !chipSelectN)
        else $error("output enable differs from select");
    a_done_deselected: assert property (chipSelectN |-> outputDoneFlag)
        else $error("done flag low while deselected");
    a_done_on_select: assert property ($fell(chipSelectN) |-> !outputDoneFlag)
        else $error("done flag high at frame start");
    a_acq_length: assert property ($fell(sampleEnable) |-> acqCount == ACQ_CLKS)
        else $error("acquisition length wrong");
    a_program_enable_n_length: assert property ($rose(endOfConversion)
        && operatingMode == MODE_CONVERT |-> convCount == PROGRAM_ENABLE_N_CLKS)
        else $error("conversion length wrong");
    a_busy_in_acq: assert property ($rose(sampleEnable) |-> !endOfConversion)
        else $error("acquiring while not busy");
    a_readonly_no_start: assert property (peCount >= 8 |-> !$fell(endOfConversion))
        else $error("conversion started in read-only mode");
    a_abort_restart: assert property ($fell(chipSelectN) && !endOfConversion
        && !sampleEnable && !programEnableN |-> ##[1:4] sampleEnable)
        else $error("select fall did not restart acquisition");
    a_reset_idle: assert property (disable iff (1'b0) sys_rst
        |=> endOfConversion && !sampleEnable)
        else $error("not idle after reset");
endmodule // asq_sequencer_checker

bind asq_sequencer asq_sequencer_checker #(.ACQ_CLKS(ACQ_CLKS), .PROGRAM_ENABLE_N_CLKS(PROGRAM_ENABLE_N_CLKS))
    asq_sequencer_checker_inst (.clock(clock), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
    .programEnableN(programEnableN), .serialOutEn(serialOutEn),
    .outputDoneFlag(outputDoneFlag), .endOfConversion(endOfConversion),
    .sampleEnable(sampleEnable), .operatingMode(operatingMode));

`default_nettype wire

// [tb/asq_host_model.sv]
// Host serial port model driving select, serial clock and command bits.
// Assumes the bench calls frame with the length the device expects.
`timescale 1ns/1ns
`default_nettype none

module asq_host_model (
    output logic serialClock,
    output logic chipSelectN,
    output logic serialIn,
    input wire logic serialOut,
    input wire logic outputDoneFlag,
    input wire logic endOfConversion
);
    // ****************************************
    // Frame generation
    // ****************************************
    initial begin
        serialClock = 1'b0;
        chipSelectN = 1'b1;
        serialIn = 1'b0;
    end

    // Serial clock runs only inside frames, 15 ns period
    task automatic frame(input logic [7:0] cmd, input int len, input bit hold,
        output logic [16:0] rx, output logic doneOk);
        rx = '0;
        doneOk = 1'b1;
        if (chipSelectN) begin
            #5 chipSelectN = 1'b0; // Clock is low here
            #3 doneOk = !outputDoneFlag;
        end else begin
            @(posedge endOfConversion) #3;
        end
        for (int k = 1; k <= len; k++) begin // Exactly len pulses
            rx = {rx[15:0], serialOut};
            serialIn = (k <= 8) ? cmd[8-k] : ~serialIn; // Command bit 7 first
            #4 serialClock = 1'b1;
            #8 serialClock = 1'b0;
            #3;
            if (k < len) doneOk &= !outputDoneFlag;
            else doneOk &= outputDoneFlag;
        end
        if (!hold) begin
            #5 chipSelectN = 1'b1;
            serialIn = ~serialIn; // Released line shows no stale value
        end
    endtask
endmodule // asq_host_model

`default_nettype wire

// [tb/asq_sequencer_bench.sv]
// Self-checking bench for the converter serial port sequencer.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none

module asq_sequencer_bench;
    import asq_pkg::*;

    logic clock, sysRst, programEnableN, serialClock, chipSelectN, serialIn;
    logic serialOut, serialOutEn, outputDoneFlag, endOfConversion, sampleEnable;
    logic [12:0] convResult;
    logic [12:0] lastRes;
    logic [2:0] channelSelect;
    asq_mode_t operatingMode;
    logic [16:0] rx;
    logic ok;
    int mismatches = 0;
    int checkCount = 0;
    int curLen = 13;

    // Short cycle counts keep the run brief
    asq_sequencer #(.ACQ_CLKS(4), .PROGRAM_ENABLE_N_CLKS(8), .CAL_CLKS(4), .ZERO_CLKS(4), .PD_CLKS(4))
        asq_sequencer_inst (.clock(clock), .sys_rst(sysRst), .serialClock(serialClock),
        .chipSelectN(chipSelectN), .serialIn(serialIn), .programEnableN(programEnableN),
        .conversionResult(convResult), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .outputDoneFlag(outputDoneFlag), .endOfConversion(endOfConversion),
        .sampleEnable(sampleEnable), .channelSelect(channelSelect),
        .operatingMode(operatingMode));

    asq_host_model asq_host_model_inst (.serialClock(serialClock), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .serialOut(serialOut), .outputDoneFlag(outputDoneFlag),
        .endOfConversion(endOfConversion));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic [16:0] expWord(input logic [12:0] res, input int len);
        return {res, 4'h0} >> (17 - len);
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (400) begin
            @(posedge clock);
            n = (endOfConversion === 1'b1) ? n + 1 : 0;
            if (n == 12) break;
        end
        chk(17'(n), 17'h0C);
    endtask

    task automatic convert(input logic [7:0] cmd, input logic [12:0] res, input bit chkData);
        @(posedge clock) convResult <= res;
        asq_host_model_inst.frame(cmd, curLen, 1'b0, rx, ok);
        if (chkData) chk(rx, expWord(lastRes, curLen));
        chk({16'h0, ok}, 17'h1);
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk({16'h0, endOfConversion}, 17'h0);
        wait_idle();
        if (cmd[7:5] == 3'h0) lastRes = res;
        curLen = (cmd[4:3] == 2'h1) ? 17 : (cmd[4:3] == 2'h2) ? 9 : 13;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_lengths();
        logic [1:0] sel [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
        for (int i = 0; i < 5; i++) begin
            convert({3'h0, sel[i], 3'(i)}, 13'h1555 ^ 13'(i * 243), i > 0);
            chk({14'h0, channelSelect}, 17'(i));
            chk({14'h0, operatingMode}, 17'h0);
        end
    endtask

    task automatic t_modes();
        for (int m = 1; m < 5; m++) begin
            convert({3'(m), 2'h0, 3'h6}, 13'h0ABC, 1'b0);
            chk({14'h0, operatingMode}, 17'(m));
        end
        convert(8'h05, 13'h1F0F, 1'b0);
    endtask

    task automatic t_abort();
        @(posedge clock) convResult <= 13'h0123;
        asq_host_model_inst.frame(8'h02, curLen, 1'b0, rx, ok);
        // Select falls mid-conversion, so the abort lands in the convert state
        repeat (7) @(posedge clock);
        @(posedge clock) convResult <= 13'h1E3C;
        asq_host_model_inst.frame(8'h02, curLen, 1'b0, rx, ok); // Data discarded
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk({16'h0, sampleEnable}, 17'h1);
        wait_idle();
        lastRes = 13'h1E3C;
        convert(8'h02, 13'h0F0F, 1'b1);
    endtask

    task automatic t_continuous();
        @(posedge clock) convResult <= 13'h1234;
        asq_host_model_inst.frame(8'h01, curLen, 1'b1, rx, ok);
        chk(rx, expWord(lastRes, curLen));
        asq_host_model_inst.frame(8'h01, curLen, 1'b0, rx, ok);
        chk(rx, expWord(13'h1234, curLen));
        chk({16'h0, ok}, 17'h1);
        wait_idle();
        // Toggled frame only once idle, so it aborts nothing
        asq_host_model_inst.frame(8'h01, curLen, 1'b0, rx, ok);
        chk(rx, expWord(13'h1234, curLen));
        wait_idle();
        lastRes = 13'h1234;
    endtask

    task automatic t_readonly();
        @(posedge clock) programEnableN <= 1'b1;
        repeat (10) @(posedge clock);
        repeat (2) begin
            asq_host_model_inst.frame(8'h0B, curLen, 1'b0, rx, ok);
            chk(rx, expWord(lastRes, curLen));
            repeat (10) @(posedge clock);
            chk({14'h0, channelSelect}, 17'h1);
            chk({16'h0, endOfConversion}, 17'h1);
        end
    endtask

    initial begin
        sysRst = 1'b0;
        programEnableN = 1'b0;
        convResult = '0;
        lastRes = '0;
        // Rises after time zero so the link's asynchronous clears see an edge
        @(posedge clock) sysRst <= 1'b1;
        repeat (20) @(posedge clock);
        sysRst <= 1'b0;
        repeat (5) @(posedge clock);
        t_lengths();
        t_modes();
        t_abort();
        t_continuous();
        t_readonly();
        give_verdict();
    end

    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        give_verdict();
    end
endmodule // asq_sequencer_bench

`default_nettype wire
